//--- dv/power_mode_and_boot_config_tb.sv
`timescale 1ns/10ps
module power_mode_and_boot_config_tb;
   import pmbc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [PMBC_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er;
   logic irq_any = 1'b0, rtc_irq = 1'b0, ext_irq_pin = 1'b0, debug_req_pin = 1'b0;
   logic reg_low = 1'b0, main_low = 1'b0, wdt_overflow = 1'b0;
   logic [7:0] img = 8'h71;
   logic pfull = 1'b0, ppart = 1'b1;
   logic [6:0] pend = 7'h03;
   logic [PMBC_FA_W-1:0] flash_addr = '0;
   logic flash_protected, cpu_clk_stop, fast_clk_off, ulp_sleep, watchdog_run, sys_clk_tick;
   logic [1:0] rate_sel, lvr_sel, lvw_sel;
   logic lv_reset_req, lv_warning_irq, wdt_reset_req, boot_from_loader;
   int num_errors = 0;
   int n_checks = 0;

   // Free-running bus clock, 100 MHz
   always #5 pclk = ~pclk;

   pmbc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_any(irq_any), .rtc_irq(rtc_irq), .ext_irq_pin(ext_irq_pin),
      .debug_req_pin(debug_req_pin), .regulated_supply_low_pin(reg_low),
      .main_supply_low_pin(main_low), .wdt_overflow(wdt_overflow),
      .image_config_second(img), .image_prot_full(pfull), .image_prot_partial(ppart),
      .image_prot_end_sector(pend), .flash_addr(flash_addr),
      .flash_protected(flash_protected), .cpu_clk_stop(cpu_clk_stop),
      .fast_clk_off(fast_clk_off), .ulp_sleep(ulp_sleep), .watchdog_run(watchdog_run),
      .sys_clk_tick(sys_clk_tick), .system_clock_rate_select(rate_sel),
      .reset_threshold_select(lvr_sel), .warning_threshold_select(lvw_sel),
      .lv_reset_req(lv_reset_req), .lv_warning_irq(lv_warning_irq),
      .wdt_reset_req(wdt_reset_req), .boot_from_loader(boot_from_loader));

   task automatic complete_run;
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      n_checks++;
      if (a !== e) begin
         num_errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   // One APB transfer; held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [PMBC_AW-1:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      if (i == 20) chk(1, 0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset(input logic [7:0] im, input logic f, input logic p);
      @(posedge pclk);
      presetn <= 1'b0;
      img <= im;
      pfull <= f;
      ppart <= p;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // Reset values, read-only image register, reserved bits, unmapped place
   task automatic t_regs;
      apb(0, PMBC_ADDR_PWR, 0); chk(PMBC_PWR_RST, rd);
      apb(0, PMBC_ADDR_CF1, 0); chk(PMBC_CF1_RST, rd);
      apb(1, PMBC_ADDR_CF2, 8'h00);
      apb(0, PMBC_ADDR_CF2, 0); chk(32'h71, rd);
      chk(4'h5, {lvr_sel, lvw_sel});
      apb(0, 18'h00100, 0); chk(32'h0, rd);
      chk(32'h1, {31'h0, er});
      apb(1, PMBC_ADDR_PWR, 8'hF8);
      apb(0, PMBC_ADDR_PWR, 0); chk(32'h38, rd);
      repeat (3) @(posedge pclk);
      chk(0, cpu_clk_stop);
      apb(1, PMBC_ADDR_PWR, 8'h00);
      apb(1, PMBC_ADDR_CF1, 8'hFF);
      apb(0, PMBC_ADDR_CF1, 0); chk(32'hE6, rd);
   endtask

   // Every power mode, refused and accepted wake sources
   task automatic t_modes;
      logic [7:0] code[6] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h04};
      logic [2:0] ex[6] = '{3'b100, 3'b110, 3'b110, 3'b111, 3'b111, 3'b000};
      int src[6] = '{0, 1, 2, 3, 1, 0};
      apb(1, PMBC_ADDR_CF1, 8'h20);
      for (int k = 0; k < 6; k++) begin
         // Bench has no converter, engine or driver enables to switch off first
         apb(1, PMBC_ADDR_PWR, code[k]);
         repeat (3) @(posedge pclk);
         chk(ex[k], {cpu_clk_stop, fast_clk_off, ulp_sleep});
         chk(!ex[k][2], watchdog_run);
         if (k == 5) break;
         if (ex[k][1]) begin
            irq_any <= 1'b1;
            repeat (6) @(posedge pclk);
            chk(1, cpu_clk_stop);
         end
         irq_any <= (src[k] == 0);
         rtc_irq <= (src[k] == 1);
         debug_req_pin <= (src[k] == 2);
         ext_irq_pin <= (src[k] == 3);
         repeat (2) @(posedge pclk);
         {irq_any, rtc_irq, debug_req_pin, ext_irq_pin} <= 4'h0;
         repeat (6) @(posedge pclk);
         chk(3'b000, {cpu_clk_stop, fast_clk_off, ulp_sleep});
         apb(0, PMBC_ADDR_PWR, 0); chk(0, rd);
      end
      apb(0, PMBC_ADDR_PWR, 0); chk(32'h04, rd);
      apb(1, PMBC_ADDR_PWR, 8'h00);
   endtask

   // Rate code sets the strobe spacing; watchdog enable bit
   task automatic t_rate;
      int n;
      for (int c = 0; c < 4; c++) begin
         apb(1, PMBC_ADDR_CF1, {5'b00000, c[1:0], 1'b0});
         repeat (3) @(posedge pclk);
         chk(c, rate_sel);
         chk(0, watchdog_run);
         n = 0;
         repeat (32) begin
            @(posedge pclk);
            if (sys_clk_tick === 1'b1) n++;
         end
         chk(32 >> c, n);
      end
   endtask

   // Supply monitor enables against detector levels
   task automatic t_lv;
      reg_low <= 1'b1;
      main_low <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         apb(1, PMBC_ADDR_CF1, {c[1:0], 6'h00});
         repeat (5) @(posedge pclk);
         chk(!c[1], lv_reset_req);
         chk(c == 1, lv_warning_irq);
      end
      reg_low <= 1'b0;
      main_low <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(0, {lv_reset_req, lv_warning_irq});
   endtask

   // Overflow outcome follows the image enables
   task automatic t_wdt(input logic exp);
      @(posedge pclk);
      wdt_overflow <= 1'b1;
      @(posedge pclk);
      wdt_overflow <= 1'b0;
      @(posedge pclk);
      chk({exp, exp}, {wdt_reset_req, boot_from_loader});
   endtask

   task automatic t_flash(input logic [13:0] a, input logic exp);
      flash_addr <= a;
      repeat (2) @(posedge pclk);
      chk(exp, flash_protected);
   endtask

   initial begin
      do_reset(8'h71, 1'b0, 1'b1);
      t_regs();
      t_modes();
      t_rate();
      t_lv();
      t_wdt(1'b1);
      t_flash(14'h01FF, 1'b1);
      t_flash(14'h0200, 1'b0);
      t_flash(14'h3F80, 1'b1);
      do_reset(8'h8E, 1'b1, 1'b0);
      apb(0, PMBC_ADDR_CF2, 0); chk(32'h82, rd);
      chk(4'hA, {lvr_sel, lvw_sel});
      t_wdt(1'b0);
      t_flash(14'h0200, 1'b1);
      complete_run();
   end

   // Hang guard
   initial begin
      #300000;
      num_errors++;
      complete_run();
   end
endmodule

//--- pkg/pmbc_pkg.sv
package pmbc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] PMBC_IDX_PWR = 16'h0087;
   localparam logic [15:0] PMBC_IDX_CF2 = 16'h401D;
   localparam logic [15:0] PMBC_IDX_CF1 = 16'h401E;
   localparam int PMBC_AW = 18;
   localparam logic [PMBC_AW-1:0] PMBC_ADDR_PWR = {PMBC_IDX_PWR, 2'b00};
   localparam logic [PMBC_AW-1:0] PMBC_ADDR_CF2 = {PMBC_IDX_CF2, 2'b00};
   localparam logic [PMBC_AW-1:0] PMBC_ADDR_CF1 = {PMBC_IDX_CF1, 2'b00};

   // Reset values
   localparam logic [7:0] PMBC_PWR_RST = 8'h00;
   localparam logic [7:0] PMBC_CF1_RST = 8'h00;
   localparam logic [7:0] PMBC_CF2_RST = 8'h00;

   // Power control fields
   localparam int PMBC_PC_IDLE = 0;
   localparam int PMBC_PC_STOP = 1;
   localparam int PMBC_PC_DEEP = 2;
   localparam logic [7:0] PMBC_PC_WMASK = 8'h3F;
   localparam logic [7:0] PMBC_PC_MODEMASK = 8'h07;

   // First configuration fields
   localparam int PMBC_C1_LVDIS = 7;
   localparam int PMBC_C1_WARN_IE = 6;
   localparam int PMBC_C1_WDOG_EN = 5;
   localparam int PMBC_C1_RATE = 1;
   localparam logic [7:0] PMBC_C1_WMASK = 8'hE6;

   // Second configuration fields
   localparam int PMBC_C2_LVR = 6;
   localparam int PMBC_C2_WDTBOOT = 5;
   localparam int PMBC_C2_WDTRST = 4;
   localparam int PMBC_C2_LVW = 0;
   localparam logic [7:0] PMBC_C2_MASK = 8'hF3;

   // Flash sector geometry: 128-byte sectors in a 16 kB array
   localparam int PMBC_FA_W = 14;
   localparam int PMBC_SEC_LSB = 7;
   localparam logic [6:0] PMBC_LAST_SEC = 7'h7F;

   // Power modes
   typedef enum logic [1:0] {PM_NORMAL, PM_STANDBY, PM_SLEEP, PM_ULP} pmbc_mode_t;
endpackage

//--- verilog/pmbc_rate.sv
`timescale 1ns/10ps
// System clock rate strobe: one pulse every 1, 2, 4 or 8 cycles
module pmbc_rate (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Rate code and strobe
   input wire logic [1:0] sel,
   output logic tick
);
   logic [2:0] cnt_reg;
   logic [2:0] mask;

   // Code n divides by two to the n
   always_comb begin
      mask = 3'((4'h1 << sel) - 4'h1);
   end

   // Free running count; strobe when the selected low bits wrap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 3'h0;
         tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
         tick <= ((cnt_reg & mask) == 3'h0);
      end
   end
endmodule

//--- verilog/pmbc_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin-level inputs
module pmbc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

//--- verilog/pmbc_top.sv
`timescale 1ns/10ps
// Functional notes
// - Low three control bits decode as normal, standby, sleep or ultra-low sleep.
// - Standby stops the processor clock and the watchdog; normal mode follows own enables.
// - Any interrupt, reset or debug request ends standby.
// - Sleep cuts the fast clock and keeps the watchdog disabled.
// - Sleep ends only on external or RTC interrupt, reset or debug.
// - Deep-sleep bit picks ultra-low sleep, only while sleep bit is set.
// - Wakeup clears the sleep, standby and deep-sleep bits in hardware.
// - Bits five to three are plain software flags without effect.
// - Supply reset fires below threshold unless the disable bit is one.
// - Warning interrupt needs detect disable low and warning enable high.
// - Configuration bit five enables the watchdog.
// - Rate field picks full, half, quarter or eighth system clock rate.
// - Second register bits seven to six choose the reset threshold.
// - Second register bits one to zero choose the warning threshold.
// - Boot-on-watchdog bit restarts from boot code after watchdog reset.
// - Watchdog overflow resets the chip when the reset enable is set.
// - Second configuration register loads from the image, read-only to software.
// - The last 128-byte flash sector is always protected.
// - Partial mode guards sectors zero to end sector; full mode guards all.
module pmbc_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmbc_pkg::PMBC_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wake sources: on-chip ones share pclk, pins are synchronised
   input wire logic irq_any,
   input wire logic rtc_irq,
   input wire logic ext_irq_pin,
   input wire logic debug_req_pin,
   // Analog detector levels
   input wire logic regulated_supply_low_pin,
   input wire logic main_supply_low_pin,
   // Watchdog
   input wire logic wdt_overflow,
   // Programmed image, valid from reset
   input wire logic [7:0] image_config_second,
   input wire logic image_prot_full,
   input wire logic image_prot_partial,
   input wire logic [6:0] image_prot_end_sector,
   // Flash access check
   input wire logic [pmbc_pkg::PMBC_FA_W-1:0] flash_addr,
   output logic flash_protected,
   // Clock and power controls
   output logic cpu_clk_stop,
   output logic fast_clk_off,
   output logic ulp_sleep,
   output logic watchdog_run,
   output logic sys_clk_tick,
   output logic [1:0] system_clock_rate_select,
   // Supply monitor
   output logic [1:0] reset_threshold_select,
   output logic [1:0] warning_threshold_select,
   output logic lv_reset_req,
   output logic lv_warning_irq,
   // Watchdog outcome
   output logic wdt_reset_req,
   output logic boot_from_loader
);
   import pmbc_pkg::*;

   logic [7:0] power_control_reg;
   logic [7:0] boot_config_first_reg;
   logic [7:0] boot_config_second_reg;
   logic loaded_reg;
   logic prot_full_reg;
   logic prot_partial_reg;
   logic [6:0] prot_end_reg;
   pmbc_mode_t mode_reg;
   pmbc_mode_t mode_next;
   logic [3:0] pins_s;
   logic ext_irq_s;
   logic debug_s;
   logic vdd_low_s;
   logic vcc_low_s;
   logic wake;
   logic acc;
   logic wr_en;
   logic hit;
   logic [7:0] rd_byte;
   logic [6:0] sector;

   // Pin levels cross into pclk before use
   pmbc_sync #(.W(4)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({ext_irq_pin, debug_req_pin, regulated_supply_low_pin, main_supply_low_pin}),
      .q(pins_s)
   );
   assign ext_irq_s = pins_s[3];
   assign debug_s = pins_s[2];
   assign vdd_low_s = pins_s[1];
   assign vcc_low_s = pins_s[0];

   // Strobe at the rate picked by the first configuration register
   pmbc_rate u_rate (
      .clk(pclk),
      .rst_n(presetn),
      .sel(boot_config_first_reg[PMBC_C1_RATE+:2]),
      .tick(sys_clk_tick)
   );

   // Access decode; one wait state so every output stays registered
   assign acc = psel & penable;
   assign wr_en = acc & pwrite & pready;
   assign hit = (paddr == PMBC_ADDR_PWR) | (paddr == PMBC_ADDR_CF1) |
                (paddr == PMBC_ADDR_CF2);

   // Read mux; reserved bits are masked at the store so read as zero
   always_comb begin
      rd_byte = 8'h00;
      case (paddr)
         PMBC_ADDR_PWR: rd_byte = power_control_reg;
         PMBC_ADDR_CF1: rd_byte = boot_config_first_reg;
         PMBC_ADDR_CF2: rd_byte = boot_config_second_reg;
         default: rd_byte = 8'h00;
      endcase
   end

   // APB answer: pready one cycle after the access phase opens
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc & ~pready;
         if (acc & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= ~hit;
         end
      end
   end

   // Mode decode from the low control bits; deep bit counts only with sleep
   always_comb begin
      mode_next = PM_NORMAL;
      case ({power_control_reg[PMBC_PC_STOP], power_control_reg[PMBC_PC_IDLE]})
         2'b00: mode_next = PM_NORMAL;
         2'b01: mode_next = PM_STANDBY;
         2'b10,
         2'b11: mode_next = power_control_reg[PMBC_PC_DEEP] ? PM_ULP : PM_SLEEP;
         default: mode_next = PM_NORMAL;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= PM_NORMAL;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Wake qualification differs by mode; sleep ignores ordinary interrupts
   always_comb begin
      wake = 1'b0;
      case (mode_reg)
         PM_NORMAL: wake = 1'b0;
         PM_STANDBY: wake = irq_any | debug_s;
         PM_SLEEP,
         PM_ULP: wake = ext_irq_s | rtc_irq | debug_s;
         default: wake = 1'b0;
      endcase
   end

   // Power control: a software write beats a same-cycle wake, as it is a new request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_control_reg <= PMBC_PWR_RST;
      end else if (wr_en && paddr == PMBC_ADDR_PWR) begin
         power_control_reg <= pwdata[7:0] & PMBC_PC_WMASK;
      end else if (wake) begin
         power_control_reg <= power_control_reg & ~PMBC_PC_MODEMASK;
      end
   end

   // First configuration: software writable fields only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_config_first_reg <= PMBC_CF1_RST;
      end else if (wr_en && paddr == PMBC_ADDR_CF1) begin
         boot_config_first_reg <= pwdata[7:0] & PMBC_C1_WMASK;
      end
   end

   // Image fields caught once after reset release; writes never reach them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_reg <= 1'b0;
         boot_config_second_reg <= PMBC_CF2_RST;
         prot_full_reg <= 1'b0;
         prot_partial_reg <= 1'b0;
         prot_end_reg <= 7'h00;
      end else if (!loaded_reg) begin
         loaded_reg <= 1'b1;
         boot_config_second_reg <= image_config_second & PMBC_C2_MASK;
         prot_full_reg <= image_prot_full;
         prot_partial_reg <= image_prot_partial;
         prot_end_reg <= image_prot_end_sector;
      end
   end

   // Clock and watchdog controls follow the registered mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_clk_stop <= 1'b0;
         fast_clk_off <= 1'b0;
         ulp_sleep <= 1'b0;
         watchdog_run <= 1'b0;
      end else begin
         cpu_clk_stop <= (mode_reg != PM_NORMAL);
         fast_clk_off <= (mode_reg == PM_SLEEP) | (mode_reg == PM_ULP);
         ulp_sleep <= (mode_reg == PM_ULP);
         watchdog_run <= boot_config_first_reg[PMBC_C1_WDOG_EN] &
                         (mode_reg == PM_NORMAL);
      end
   end

   // Supply monitor; thresholds pass to the analog detectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lv_reset_req <= 1'b0;
         lv_warning_irq <= 1'b0;
         reset_threshold_select <= 2'b00;
         warning_threshold_select <= 2'b00;
         system_clock_rate_select <= 2'b00;
      end else begin
         lv_reset_req <= ~boot_config_first_reg[PMBC_C1_LVDIS] & vdd_low_s;
         lv_warning_irq <= ~boot_config_first_reg[PMBC_C1_LVDIS] &
                           boot_config_first_reg[PMBC_C1_WARN_IE] & vcc_low_s;
         reset_threshold_select <= boot_config_second_reg[PMBC_C2_LVR+:2];
         warning_threshold_select <= boot_config_second_reg[PMBC_C2_LVW+:2];
         system_clock_rate_select <= boot_config_first_reg[PMBC_C1_RATE+:2];
      end
   end

   // Watchdog overflow outcome; boot select rides with the reset pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reset_req <= 1'b0;
         boot_from_loader <= 1'b0;
      end else begin
         wdt_reset_req <= wdt_overflow & boot_config_second_reg[PMBC_C2_WDTRST];
         boot_from_loader <= wdt_overflow & boot_config_second_reg[PMBC_C2_WDTRST] &
                             boot_config_second_reg[PMBC_C2_WDTBOOT];
      end
   end

   // Flash protection lookup, one cycle latency
   assign sector = flash_addr[PMBC_FA_W-1:PMBC_SEC_LSB];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_protected <= 1'b1;
      end else begin
         flash_protected <= (sector == PMBC_LAST_SEC) |
                            prot_full_reg |
                            (prot_partial_reg & (sector <= prot_end_reg));
      end
   end

   // Checks
   sequence s_wake_clear;
      (power_control_reg[2:0] == 3'b000) ##1 (mode_reg == PM_NORMAL);
   endsequence

   property p_decode;
      @(posedge pclk) disable iff (!presetn)
      (power_control_reg[2:0] == 3'b001) |=> (mode_reg == PM_STANDBY);
   endproperty
   a_decode: assert property (p_decode) else $error("standby decode wrong");

   property p_standby;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg == PM_STANDBY) |=> cpu_clk_stop && !watchdog_run && !fast_clk_off;
   endproperty
   a_standby: assert property (p_standby) else $error("standby outputs wrong");

   property p_standby_wake;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg == PM_STANDBY && irq_any && !(wr_en && paddr == PMBC_ADDR_PWR))
         |=> s_wake_clear;
   endproperty
   a_standby_wake: assert property (p_standby_wake) else $error("no standby wake");

   property p_sleep;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg == PM_SLEEP) |=> fast_clk_off && !watchdog_run && !ulp_sleep;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");

   property p_sleep_hold;
      @(posedge pclk) disable iff (!presetn)
      ((mode_reg == PM_SLEEP || mode_reg == PM_ULP) && !ext_irq_s && !rtc_irq &&
       !debug_s && !wr_en) |=> $stable(power_control_reg);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep woke wrongly");

   property p_sleep_wake;
      @(posedge pclk) disable iff (!presetn)
      (mode_reg == PM_ULP && rtc_irq && !wr_en) |=> s_wake_clear ##1 !ulp_sleep;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("no sleep wake");

   property p_lvr;
      @(posedge pclk) disable iff (!presetn)
      (vdd_low_s && !boot_config_first_reg[PMBC_C1_LVDIS]) |=> lv_reset_req;
   endproperty
   a_lvr: assert property (p_lvr) else $error("missing supply reset");

   property p_lvw;
      @(posedge pclk) disable iff (!presetn)
      lv_warning_irq |-> $past(boot_config_first_reg[PMBC_C1_WARN_IE]) &&
                         !$past(boot_config_first_reg[PMBC_C1_LVDIS]);
   endproperty
   a_lvw: assert property (p_lvw) else $error("warning not gated");

   property p_wdt_rst;
      @(posedge pclk) disable iff (!presetn)
      (wdt_overflow && boot_config_second_reg[PMBC_C2_WDTRST]) |=> wdt_reset_req;
   endproperty
   a_wdt_rst: assert property (p_wdt_rst) else $error("missing watchdog reset");

   property p_ro;
      @(posedge pclk) disable iff (!presetn)
      (loaded_reg && wr_en && paddr == PMBC_ADDR_CF2) |=> $stable(boot_config_second_reg);
   endproperty
   a_ro: assert property (p_ro) else $error("read-only register changed");

   property p_last;
      @(posedge pclk) disable iff (!presetn)
      (sector == PMBC_LAST_SEC) |=> flash_protected;
   endproperty
   a_last: assert property (p_last) else $error("last sector unprotected");

   property p_rsv;
      @(posedge pclk) disable iff (!presetn)
      pready |-> (power_control_reg[7:6] == 2'b00) && (prdata[31:8] == 24'h00_0000);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
